// file: kwdt_regs.vh
// Register map, field positions, reset values and key codes of the
// keyed watchdog timer. Definitions only; included by kwdt_top.v.
`ifndef KWDT_REGS_VH
`define KWDT_REGS_VH

// ----------------------------------------------------------------------
// Byte offsets within the watchdog window
// ----------------------------------------------------------------------
`define KWDT_ADDR_W        24
`define KWDT_OFS_MODE      24'h224000
`define KWDT_OFS_RELOAD    24'h224004
`define KWDT_OFS_FEED      24'h224008
`define KWDT_OFS_COUNT     24'h22400c
`define KWDT_OFS_CTLKEY    24'h224010
`define KWDT_OFS_WARN      24'h224014
`define KWDT_OFS_WINDOW    24'h224018
`define KWDT_OFS_STATUS    24'h22401c
`define KWDT_OFS_ENABLE    24'h224020
`define KWDT_OFS_PRESCALE  24'h224024
`define KWDT_OFS_PCCAP     24'h224028

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define KWDT_MODE_EN       0
`define KWDT_MODE_ROF      1
`define KWDT_MODE_FLAG     2
`define KWDT_MODE_GUARD    3
`define KWDT_EV_WARN       0
`define KWDT_EV_FEEDERR    1
`define KWDT_EV_TIMEOUT    2
`define KWDT_EV_PROTERR    3

// ----------------------------------------------------------------------
// Reset values and reload minimum
// ----------------------------------------------------------------------
`define KWDT_RST_RELOAD    24'h0000ff
`define KWDT_RST_COUNT     24'h0000ff
`define KWDT_RST_WINDOW    24'hffffff
`define KWDT_RST_PRESCALE  8'hff
`define KWDT_RELOAD_MIN    24'h0000ff

// ----------------------------------------------------------------------
// Key codes
// ----------------------------------------------------------------------
`define KWDT_FEED_KEY1     8'haa
`define KWDT_FEED_KEY2     8'h55
`define KWDT_CTL_KEY1      8'h5a
`define KWDT_CTL_ALL       8'ha0
`define KWDT_CTL_EN        8'ha1
`define KWDT_CTL_ROF       8'ha2
`define KWDT_CTL_GUARD     8'ha3

`endif

// file: kwdt_top.v
// Keyed watchdog timer: down counter, keyed feed and control clear,
// feed window, reload guard, warning threshold, four event flags, PC capture.
// Assumes an Avalon-MM master on MCLK and a separate power-on reset input.
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "kwdt_regs.vh"

module kwdt_top (
   // Clock and resets
   input  wire        MCLK,
   input  wire        RST_N,
   input  wire        POR_N,
   // Peripheral clock tick and processor program counter
   input  wire        PCLK_TICK,
   input  wire [22:0] CPU_PC,
   // Avalon-MM slave
   input  wire [23:0] AVS_ADDRESS,
   input  wire        AVS_READ,
   input  wire        AVS_WRITE,
   input  wire [31:0] AVS_WRITEDATA,
   input  wire [3:0]  AVS_BYTEENABLE,
   output reg  [31:0] AVS_READDATA,
   output reg         AVS_WAITREQUEST,
   // Watchdog outputs
   output reg         WDOG_IRQ,
   output reg         WDOG_RESET
);

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   reg        dog_enable;
   reg        reset_on_fault;
   reg        reload_guard;
   reg        fault_flag;
   reg [23:0] reload_constant;
   reg [23:0] dog_timer;
   reg        running;
   reg [23:0] count_value;
   reg [9:0]  warn_threshold;
   reg [23:0] feed_window;
   reg [3:0]  event_status;
   reg [3:0]  event_enable;
   reg [7:0]  tick_prescale;
   reg [7:0]  prescale_count;
   reg [22:0] program_counter_capture;
   reg        feed_armed;
   reg        ctl_armed;
   reg        done;

   // -------------------------------------------------------------------
   // Bus decode
   // -------------------------------------------------------------------
   // Each access is taken one cycle after it appears; waitrequest is
   // low only in that cycle, so every access costs exactly two cycles.
   wire       req      = (AVS_READ | AVS_WRITE) & ~done;
   wire       wr       = AVS_WRITE & req;
   wire [7:0] wbyte    = AVS_WRITEDATA[7:0];
   wire       lane0    = AVS_BYTEENABLE[0];
   wire       hit_mode = AVS_ADDRESS == `KWDT_OFS_MODE;
   wire       hit_rel  = AVS_ADDRESS == `KWDT_OFS_RELOAD;
   wire       hit_feed = AVS_ADDRESS == `KWDT_OFS_FEED;
   wire       hit_ctl  = AVS_ADDRESS == `KWDT_OFS_CTLKEY;
   wire       hit_warn = AVS_ADDRESS == `KWDT_OFS_WARN;
   wire       hit_win  = AVS_ADDRESS == `KWDT_OFS_WINDOW;
   wire       hit_st   = AVS_ADDRESS == `KWDT_OFS_STATUS;
   wire       hit_en   = AVS_ADDRESS == `KWDT_OFS_ENABLE;
   wire       hit_pre  = AVS_ADDRESS == `KWDT_OFS_PRESCALE;
   wire       hit_any  = hit_mode | hit_rel | hit_feed | hit_ctl | hit_warn |
                         hit_win | hit_st | hit_en | hit_pre |
                         (AVS_ADDRESS == `KWDT_OFS_COUNT) |
                         (AVS_ADDRESS == `KWDT_OFS_PCCAP);
   wire       acc      = req & hit_any;

   // -------------------------------------------------------------------
   // Key sequences and fault detection
   // -------------------------------------------------------------------
   wire feed_good  = wr & hit_feed & lane0 & (wbyte == `KWDT_FEED_KEY2);
   wire ctl_code   = (wbyte == `KWDT_CTL_ALL) | (wbyte == `KWDT_CTL_EN) |
                     (wbyte == `KWDT_CTL_ROF) | (wbyte == `KWDT_CTL_GUARD);
   wire ctl_good   = wr & hit_ctl & lane0 & ctl_code;
   wire feed_seq   = feed_armed & feed_good;
   wire ctl_seq    = ctl_armed & ctl_good;
   wire seq_broken = acc & ((feed_armed & ~feed_good) |
                            (ctl_armed & ~ctl_good));
   wire early_feed = feed_seq & (dog_timer > feed_window);
   wire feed_err   = seq_broken | early_feed;
   wire feed_ok    = feed_seq & ~early_feed;
   wire rel_wr     = wr & hit_rel & ~feed_armed & ~ctl_armed;
   wire prot_err   = rel_wr & reload_guard &
                     ~(dog_timer < feed_window);
   wire rel_ok     = rel_wr & ~prot_err;
   // Compare with >= so that lowering tick_prescale while the prescaler
   // is above the new limit ends the period at once instead of wrapping.
   wire tick       = PCLK_TICK & (prescale_count >= tick_prescale);
   wire timeout    = running & dog_enable & tick &
                     (dog_timer == 24'h000001);
   wire warn_hit   = dog_timer <= {14'h0000, warn_threshold};
   wire fault      = timeout | feed_err | prot_err;
   // Writes inside a broken sequence do not count as ordinary writes; a write counts
   // only when no sequence is armed; this keeps a stray store harmless.
   wire plain_wr   = wr & ~feed_armed & ~ctl_armed;

   // -------------------------------------------------------------------
   // Key sequence tracking
   // -------------------------------------------------------------------
   always @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         feed_armed <= 1'b0;
         ctl_armed  <= 1'b0;
      end else if (acc) begin
         feed_armed <= ~feed_armed & ~ctl_armed & wr & hit_feed & lane0 &
                       (wbyte == `KWDT_FEED_KEY1);
         ctl_armed  <= ~feed_armed & ~ctl_armed & wr & hit_ctl & lane0 &
                       (wbyte == `KWDT_CTL_KEY1);
      end
   end

   // -------------------------------------------------------------------
   // Enable, reset-on-fault and guard mode bits: plain writes set, the control key clears
   // -------------------------------------------------------------------
   always @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         dog_enable     <= 1'b0;
         reset_on_fault <= 1'b0;
         reload_guard   <= 1'b0;
      end else if (ctl_seq) begin
         if (wbyte == `KWDT_CTL_ALL || wbyte == `KWDT_CTL_EN)
            dog_enable <= 1'b0;
         if (wbyte == `KWDT_CTL_ALL || wbyte == `KWDT_CTL_ROF)
            reset_on_fault <= 1'b0;
         if (wbyte == `KWDT_CTL_ALL || wbyte == `KWDT_CTL_GUARD)
            reload_guard <= 1'b0;
      end else if (plain_wr && hit_mode && lane0) begin
         dog_enable     <= dog_enable | wbyte[`KWDT_MODE_EN];
         reset_on_fault <= reset_on_fault | wbyte[`KWDT_MODE_ROF];
         reload_guard   <= reload_guard | wbyte[`KWDT_MODE_GUARD];
      end
   end

   // Survives the watchdog's own reset; only power-on or a mode write with the flag bit at 0 clears it.
   always @(posedge MCLK or negedge POR_N) begin
      if (!POR_N)
         fault_flag <= 1'b0;
      else if (fault)
         fault_flag <= 1'b1;
      else if (plain_wr && hit_mode && lane0 && !wbyte[`KWDT_MODE_FLAG])
         fault_flag <= 1'b0;
   end

   always @(posedge MCLK or negedge POR_N) begin
      if (!POR_N)
         program_counter_capture <= 23'h000000;
      else if ((warn_hit && !event_status[`KWDT_EV_WARN]) ||
               feed_err || prot_err)
         program_counter_capture <= CPU_PC;
   end

   // -------------------------------------------------------------------
   // Configuration registers
   // -------------------------------------------------------------------
   always @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         reload_constant <= `KWDT_RST_RELOAD;
         warn_threshold  <= 10'h000;
         feed_window     <= `KWDT_RST_WINDOW;
         event_enable    <= 4'h0;
         tick_prescale   <= `KWDT_RST_PRESCALE;
      end else if (plain_wr) begin
         if (rel_ok) begin
            if (AVS_WRITEDATA[23:0] < `KWDT_RELOAD_MIN)
               reload_constant <= `KWDT_RELOAD_MIN;
            else
               reload_constant <= AVS_WRITEDATA[23:0];
         end
         if (hit_warn)
            warn_threshold <= AVS_WRITEDATA[9:0];
         if (hit_win)
            feed_window <= AVS_WRITEDATA[23:0];
         if (hit_en && lane0)
            event_enable <= wbyte[3:0];
         if (hit_pre && lane0)
            tick_prescale <= wbyte;
      end
   end

   // -------------------------------------------------------------------
   // Event status: set wins over write-one-to-clear
   // -------------------------------------------------------------------
   wire [3:0] ev_set = {prot_err, timeout, feed_err, warn_hit};
   wire [3:0] ev_clr = (plain_wr && hit_st && lane0) ? wbyte[3:0] : 4'h0;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_ev
         always @(posedge MCLK or negedge RST_N) begin
            if (!RST_N)
               event_status[gi] <= 1'b0;
            else if (ev_set[gi])
               event_status[gi] <= 1'b1;
            else if (ev_clr[gi])
               event_status[gi] <= 1'b0;
         end
      end
   endgenerate

   // -------------------------------------------------------------------
   // Prescaler and down counter
   // -------------------------------------------------------------------
   always @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         prescale_count <= 8'h00;
         dog_timer      <= `KWDT_RST_COUNT;
         running        <= 1'b0;
         count_value    <= `KWDT_RST_COUNT;
      end else begin
         count_value <= dog_timer;
         if (feed_ok) begin
            dog_timer      <= reload_constant;
            prescale_count <= 8'h00;
            running        <= dog_enable;
         end else if (running && dog_enable && PCLK_TICK) begin
            if (tick) begin
               prescale_count <= 8'h00;
               if (dog_timer != 24'h000000)
                  dog_timer <= dog_timer - 24'h000001;
               else
                  running <= 1'b0;
            end else begin
               prescale_count <= prescale_count + 8'h01;
            end
         end
      end
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   // WDOG_RESET is a one-cycle pulse per fault; the chip reset
   // distribution outside this block must stretch it if it needs more.
   // Read data are zero outside the answering cycle, so a fabric that
   // ORs slave read data together needs no further gating.
   always @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         done            <= 1'b0;
         AVS_WAITREQUEST <= 1'b1;
         AVS_READDATA    <= 32'h00000000;
         WDOG_IRQ        <= 1'b0;
         WDOG_RESET      <= 1'b0;
      end else begin
         done            <= req;
         AVS_WAITREQUEST <= ~req;
         WDOG_IRQ        <= |(event_status & event_enable);
         WDOG_RESET      <= reset_on_fault & fault;
         AVS_READDATA    <= 32'h00000000;
         if (AVS_READ && req) begin
            case (AVS_ADDRESS)
               `KWDT_OFS_MODE:     AVS_READDATA <= {28'h0000000,
                                      reload_guard, fault_flag,
                                      reset_on_fault, dog_enable};
               `KWDT_OFS_RELOAD:   AVS_READDATA <= {8'h00, reload_constant};
               `KWDT_OFS_COUNT:    AVS_READDATA <= {8'h00, count_value};
               `KWDT_OFS_WARN:     AVS_READDATA <= {22'h000000,
                                                    warn_threshold};
               `KWDT_OFS_WINDOW:   AVS_READDATA <= {8'h00, feed_window};
               `KWDT_OFS_STATUS:   AVS_READDATA <= {28'h0000000,
                                                    event_status};
               `KWDT_OFS_ENABLE:   AVS_READDATA <= {28'h0000000,
                                                    event_enable};
               `KWDT_OFS_PRESCALE: AVS_READDATA <= {24'h000000,
                                                    tick_prescale};
               `KWDT_OFS_PCCAP:    AVS_READDATA <= {9'h000,
                                            program_counter_capture};
               default:            AVS_READDATA <= 32'h00000000;
            endcase
         end
      end
   end

endmodule // kwdt_top

`default_nettype wire

// file: kwdt_chk.sv
// Checker for the keyed watchdog: bus timing, readout widths, outputs.
// Assumes it is bound to kwdt_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
`include "kwdt_regs.vh"
module kwdt_chk (
   // Clock and resets
   input wire logic        MCLK,
   input wire logic        RST_N,
   input wire logic        POR_N,
   // Tick and program counter
   input wire logic        PCLK_TICK,
   input wire logic [22:0] CPU_PC,
   // Register bus
   input wire logic [23:0] AVS_ADDRESS,
   input wire logic        AVS_READ,
   input wire logic        AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0]  AVS_BYTEENABLE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic        AVS_WAITREQUEST,
   // Watchdog outputs
   input wire logic        WDOG_IRQ,
   input wire logic        WDOG_RESET
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   wire rd_ok = AVS_READ & ~AVS_WAITREQUEST;
   wire req   = AVS_READ | AVS_WRITE;

   a_answer_next: assert property (
      req && AVS_WAITREQUEST && $past(AVS_WAITREQUEST) |=> !AVS_WAITREQUEST)
      else $error("bus request not answered in the next cycle");
   a_answer_once: assert property (
      !req || !AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("waitrequest low without a fresh request");
   a_idle_rdata: assert property (
      AVS_WAITREQUEST |-> AVS_READDATA == 32'h0)
      else $error("read data not zero outside an answer");
   a_reload_floor: assert property (
      rd_ok && AVS_ADDRESS == `KWDT_OFS_RELOAD
      |-> AVS_READDATA[23:0] >= 24'hff && AVS_READDATA[31:24] == 8'h0)
      else $error("reload constant below floor");
   a_count_width: assert property (
      rd_ok && AVS_ADDRESS == `KWDT_OFS_COUNT |-> AVS_READDATA[31:24] == 8'h0)
      else $error("count readout wider than 24 bits");
   a_pc_width: assert property (
      rd_ok && AVS_ADDRESS == `KWDT_OFS_PCCAP |-> AVS_READDATA[31:23] == 9'h0)
      else $error("pc capture wider than 23 bits");
   a_status_width: assert property (
      rd_ok && AVS_ADDRESS == `KWDT_OFS_STATUS
      |-> AVS_READDATA[31:4] == 28'h0)
      else $error("event status wider than 4 bits");
   a_warn_width: assert property (
      rd_ok && AVS_ADDRESS == `KWDT_OFS_WARN |-> AVS_READDATA[31:10] == 22'h0)
      else $error("warn threshold wider than 10 bits");
   a_irq_masked: assert property (
      AVS_WRITE && AVS_WAITREQUEST && $past(AVS_WAITREQUEST)
      && AVS_ADDRESS == `KWDT_OFS_ENABLE && AVS_BYTEENABLE[0]
      && AVS_WRITEDATA[3:0] == 4'h0 |-> ##2 !WDOG_IRQ)
      else $error("interrupt stays high with all enables off");
   a_reset_pulse: assert property (
      WDOG_RESET |=> !WDOG_RESET)
      else $error("chip reset longer than one cycle");
endmodule // kwdt_chk

bind kwdt_top kwdt_chk i_chk (.MCLK(MCLK), .RST_N(RST_N), .POR_N(POR_N),
   .PCLK_TICK(PCLK_TICK), .CPU_PC(CPU_PC), .AVS_ADDRESS(AVS_ADDRESS),
   .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
   .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
   .AVS_WAITREQUEST(AVS_WAITREQUEST), .WDOG_IRQ(WDOG_IRQ),
   .WDOG_RESET(WDOG_RESET));
`default_nettype wire

// file: keyed_watchdog_timer_tb.sv
// Self-checking bench for the keyed watchdog: registers, keys, timer, events.
// Assumes kwdt_top and its checker are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`include "kwdt_regs.vh"
module keyed_watchdog_timer_tb;
   localparam [23:0] MD = `KWDT_OFS_MODE;
   localparam [23:0] RL = `KWDT_OFS_RELOAD;
   localparam [23:0] FD = `KWDT_OFS_FEED;
   localparam [23:0] CV = `KWDT_OFS_COUNT;
   localparam [23:0] CK = `KWDT_OFS_CTLKEY;
   localparam [23:0] WN = `KWDT_OFS_WARN;
   localparam [23:0] WI = `KWDT_OFS_WINDOW;
   localparam [23:0] ST = `KWDT_OFS_STATUS;
   localparam [23:0] EN = `KWDT_OFS_ENABLE;
   localparam [23:0] PR = `KWDT_OFS_PRESCALE;
   localparam [23:0] PC = `KWDT_OFS_PCCAP;
   logic        MCLK = 1'b0;
   logic        RST_N = 1'b0;
   logic        POR_N = 1'b0;
   logic        PCLK_TICK = 1'b1;
   logic [22:0] CPU_PC = 23'h0;
   logic [23:0] AVS_ADDRESS = 24'h0;
   logic        AVS_READ = 1'b0;
   logic        AVS_WRITE = 1'b0;
   logic [31:0] AVS_WRITEDATA = 32'h0;
   logic [3:0]  AVS_BYTEENABLE = 4'h0;
   wire  [31:0] AVS_READDATA;
   wire         AVS_WAITREQUEST;
   wire         WDOG_IRQ;
   wire         WDOG_RESET;
   int          mismatches = 0;
   int          checks_done = 0;
   int          ticks = 0;
   int          pulses = 0;
   int          t0;
   int          e;
   logic [31:0] q;
   logic [31:0] v;
   logic [22:0] pcv;

   kwdt_top i_dut (.MCLK(MCLK), .RST_N(RST_N), .POR_N(POR_N),
      .PCLK_TICK(PCLK_TICK), .CPU_PC(CPU_PC), .AVS_ADDRESS(AVS_ADDRESS),
      .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
      .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
      .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
      .WDOG_IRQ(WDOG_IRQ), .WDOG_RESET(WDOG_RESET));

   always #25 MCLK = ~MCLK;
   always @(posedge MCLK) begin
      if (PCLK_TICK) ticks <= ticks + 1;
      if (WDOG_RESET === 1'b1) pulses <= pulses + 1;
   end

   // ----------------------------------------------------------------------
   // Bus tasks
   // ----------------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         mismatches++;
      end
   endtask
   // Timer value after n peripheral ticks from a load, one step per
   // prescale period.
   function automatic int exp_count(input int load, input int pre,
                                    input int n);
      return load - n / (pre + 1);
   endfunction
   // The request stays up until waitrequest is seen low at a rising edge.
   task automatic bus(input logic wr, input logic [23:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      @(posedge MCLK);
      AVS_ADDRESS <= a;
      AVS_WRITE <= wr;
      AVS_READ <= !wr;
      AVS_WRITEDATA <= d;
      AVS_BYTEENABLE <= 4'hf;
      do begin
         @(posedge MCLK);
      end while (AVS_WAITREQUEST !== 1'b0);
      r = AVS_READDATA;
      AVS_READ <= 1'b0;
      AVS_WRITE <= 1'b0;
   endtask
   task automatic w(input logic [23:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rc(input logic [23:0] a, input logic [31:0] m,
                     input logic [31:0] x);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(r & m, x);
   endtask
   task automatic feed;
      w(FD, 32'haa);
      w(FD, 32'h55);
   endtask
   task automatic finish_test;
      if (mismatches == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge MCLK);
      mismatches++;
      finish_test;
   end

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      void'($urandom(4796));
      repeat (12) @(posedge MCLK);
      RST_N <= 1'b1;
      POR_N <= 1'b1;
      rc(MD, '1, 32'h0);
      rc(RL, '1, 32'hff);
      rc(CV, '1, 32'hff);
      rc(WN, '1, 32'h0);
      rc(WI, '1, 32'hffffff);
      rc(ST, '1, 32'h0);
      rc(EN, '1, 32'h0);
      rc(PR, '1, 32'hff);
      rc(PC, '1, 32'h0);
      w(24'h22402c, '1);
      rc(24'h22402c, '1, 32'h0);
      w(RL, 32'h10);
      rc(RL, '1, 32'hff);
      v = 32'h100 + ($urandom & 32'hffff);
      w(RL, v);
      rc(RL, '1, v);
      repeat (4) begin
         v = $urandom;
         w(WN, v);
         rc(WN, '1, v & 32'h3ff);
         v = $urandom;
         w(PR, v);
         rc(PR, '1, v & 32'hff);
      end
      w(PR, 32'h3);
      w(RL, 32'h100);
      w(WN, 32'h0);
      w(ST, 32'hf);
      pcv = 23'($urandom);
      CPU_PC <= pcv;
      w(MD, 32'h1);
      repeat (20) @(posedge MCLK);
      rc(CV, '1, 32'hff);
      feed;
      t0 = ticks;
      repeat (200) begin
         PCLK_TICK <= 1'($urandom);
         @(posedge MCLK);
      end
      PCLK_TICK <= 1'b1;
      bus(1'b0, CV, 32'h0, q);
      e = exp_count(256, 3, ticks - t0);
      chk(32'(q + 3 >= e && q <= e + 6), 32'h1);
      repeat (1100) @(posedge MCLK);
      rc(CV, '1, 32'h0);
      rc(ST, 32'hf, 32'h5);
      rc(MD, 32'hf, 32'h5);
      rc(PC, '1, {9'h0, pcv});
      chk(pulses, 32'h0);
      w(MD, 32'h0);
      rc(MD, 32'hf, 32'h1);
      w(ST, 32'h4);
      rc(ST, 32'hf, 32'h1);
      w(EN, 32'h1);
      repeat (3) @(posedge MCLK);
      chk({31'h0, WDOG_IRQ}, 32'h1);
      w(EN, 32'h2);
      repeat (3) @(posedge MCLK);
      chk({31'h0, WDOG_IRQ}, 32'h0);
      w(WI, 32'h80);
      feed;
      repeat (10) @(posedge MCLK);
      bus(1'b0, CV, 32'h0, q);
      chk(32'(q >= 32'hf0 && q <= 32'h100), 32'h1);
      feed;
      rc(ST, 32'h2, 32'h2);
      repeat (3) @(posedge MCLK);
      chk({31'h0, WDOG_IRQ}, 32'h1);
      w(ST, 32'hf);
      w(FD, 32'haa);
      bus(1'b0, MD, 32'h0, q);
      rc(ST, 32'h2, 32'h2);
      w(ST, 32'hf);
      for (int i = 0; i < 4; i++) begin
         w(MD, 32'hb);
         w(CK, 32'h5a);
         w(CK, 32'ha0 + i);
         v = (i == 0) ? 32'h0 : 32'hb & ~((i == 3) ? 32'h8 : i);
         rc(MD, 32'hb, v);
      end
      w(CK, 32'h5a);
      w(CK, 32'h77);
      rc(ST, 32'h2, 32'h2);
      chk(pulses, 32'h1);
      w(CK, 32'h5a);
      w(CK, 32'ha0);
      w(ST, 32'hf);
      w(EN, 32'h0);
      w(WI, 32'hffffff);
      w(MD, 32'h9);
      feed;
      w(WI, 32'h80);
      pcv = 23'($urandom);
      CPU_PC <= pcv;
      w(RL, 32'h300);
      rc(ST, 32'h8, 32'h8);
      rc(RL, '1, 32'h100);
      rc(PC, '1, {9'h0, pcv});
      repeat (600) @(posedge MCLK);
      w(RL, 32'h300);
      rc(RL, '1, 32'h300);
      // A watchdog reset alone must keep the fault flag and the PC capture.
      RST_N <= 1'b0;
      repeat (3) @(posedge MCLK);
      RST_N <= 1'b1;
      rc(MD, 32'hf, 32'h4);
      rc(PC, '1, {9'h0, pcv});
      rc(RL, '1, 32'hff);
      rc(CV, '1, 32'hff);
      finish_test;
   end
endmodule // keyed_watchdog_timer_tb
`default_nettype wire
